// File: aim_cfg.svh
`ifndef AIM_CFG_SVH
`define AIM_CFG_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFF_CH_FIRST   8'h00
`define OFF_STAT_WORD  8'h20
`define OFF_CONFIG     8'h24
`define OFF_IRQ_STAT   8'h28
`define OFF_IRQ_MASK   8'h2C
`define OFF_MOD_STAT   8'h30
// ****************************************
// Fields and reset values
// ****************************************
`define CFG_FMT_LSB    5'h18
`define CFG_RST        32'h0000_0000
`define MASK_RST       3'h0
`define IRQ_FAULT      2'h0
`define IRQ_OVERRUN    2'h1
`define IRQ_SCAN       2'h2
`define MOD_MSB        3'h7
// ****************************************
// Range limits in mV or uA, and counts
// ****************************************
`define B10            64'sh2710
`define B5             64'sh1388
`define V1             64'sh03E8
`define I20            64'sh4E20
`define I4             64'sh0FA0
`define LOW_1_5V       64'sh01F4
`define LOW_4_20MA     64'sh0820
`define OVR_NUM        64'sh0400
`define OVR_DEN        64'sh03E8
`define FULL16         64'shFA00
`define HALF16         64'sh7D00
`define LO16_BIP10     64'sh0300
`define LO16_BIP5      64'sh4180
`define LO16_OFF       64'sh1900
`define FULL12         64'sh0FFF
`define MAX16          64'shFFFF
`define VM_MAX         64'sh7FFF
`define VM_MIN         (-64'sh8000)
// ****************************************
// Timing
// ****************************************
`define CLK_KHZ        32'h0003_0D40
`define UPDATE_MS      32'h0000_0005
`define UPDATE_CYC     (`UPDATE_MS * `CLK_KHZ)
`endif

// File: aim_pkg.sv
package aim_pkg;
  typedef enum logic [2:0] {
    rng_bip10v, rng_bip5v, rng_uni10v, rng_uni5v,
    rng_off1_5v, rng_bip20ma, rng_uni20ma, rng_off4_20ma
  } range_e;
  typedef enum logic [1:0] {fmt_u16, fmt_volt, fmt_b12} format_e;
  typedef struct packed {
    logic [15:0] word;
    logic        warn;
    logic        oor;
    logic        fault;
  } reading_s;
endpackage

// File: scale_if.sv
`timescale 1ns/1ps
interface scale_if;
  logic signed [17:0] value;
  aim_pkg::range_e    rng;
  logic [1:0]         fmt;
  logic               open_wire;
  aim_pkg::reading_s  res;
  modport requester (output value, rng, fmt, open_wire, input res);
  modport scaler (input value, rng, fmt, open_wire, output res);
endinterface

// File: reading_scaler.sv
`timescale 1ns/1ps
`include "aim_cfg.svh"
module reading_scaler (
  scale_if.scaler sio
);
  always_comb
  begin
    longint v;
    longint lo;
    longint hi;
    longint u16;
    longint q12;
    logic   cur;
    logic   over;
    v = longint'(sio.value);
    lo = 64'sh0;
    hi = 64'sh0;
    u16 = 64'sh0;
    q12 = 64'sh0;
    cur = sio.rng inside {aim_pkg::rng_bip20ma, aim_pkg::rng_uni20ma,
                          aim_pkg::rng_off4_20ma};
    if (cur && sio.open_wire)
      v = 64'sh0;
    unique case (sio.rng)
      aim_pkg::rng_bip10v:
      begin
        lo = -`B10; hi = `B10;
        u16 = ((v + `B10) * `FULL16) / (2 * `B10) + `LO16_BIP10;
        q12 = ((v + `B10) * `FULL12) / (2 * `B10);
      end
      aim_pkg::rng_bip5v:
      begin
        lo = -`B5; hi = `B5;
        u16 = ((v + `B5) * `HALF16) / (2 * `B5) + `LO16_BIP5;
        q12 = ((v + `B5) * `FULL12) / (2 * `B5);
      end
      aim_pkg::rng_uni10v:
      begin
        lo = 64'sh0; hi = `B10;
        u16 = (v * `FULL16) / `B10;
        q12 = (v * `FULL12) / `B10;
      end
      aim_pkg::rng_uni5v:
      begin
        lo = 64'sh0; hi = `B5;
        u16 = (v * `HALF16) / `B5;
        q12 = (v * `FULL12) / `B5;
      end
      aim_pkg::rng_off1_5v:
      begin
        lo = `V1; hi = `B5;
        u16 = ((v - `V1) * (`HALF16 - `LO16_OFF)) / (`B5 - `V1) + `LO16_OFF;
        q12 = ((v - `V1) * `FULL12) / (`B5 - `V1);
      end
      aim_pkg::rng_bip20ma:
      begin
        lo = -`I20; hi = `I20;
        u16 = ((v + `I20) * `HALF16) / (2 * `I20) + `LO16_BIP5;
        q12 = ((v + `I20) * `FULL12) / (2 * `I20);
      end
      aim_pkg::rng_uni20ma:
      begin
        lo = 64'sh0; hi = `I20;
        u16 = (v * `HALF16) / `I20;
        q12 = (v * `FULL12) / `I20;
      end
      aim_pkg::rng_off4_20ma:
      begin
        lo = `I4; hi = `I20;
        u16 = ((v - `I4) * (`HALF16 - `LO16_OFF)) / (`I20 - `I4) + `LO16_OFF;
        q12 = ((v - `I4) * `FULL12) / (`I20 - `I4);
      end
    endcase
    // Bipolar ranges also trip 2.4 % beyond the negative rating
    over = (v * `OVR_DEN > hi * `OVR_NUM) || (lo < 0 && v * `OVR_DEN < lo * `OVR_NUM);
    sio.res.fault = (sio.rng == aim_pkg::rng_off1_5v && v < `LOW_1_5V) ||
                    (sio.rng == aim_pkg::rng_off4_20ma && v < `LOW_4_20MA) ||
                    (sio.rng == aim_pkg::rng_off4_20ma && sio.open_wire);
    sio.res.oor = over || sio.res.fault;
    sio.res.warn = v < lo || v > hi || sio.res.oor;
    unique case (sio.fmt)
      2'h1:
        sio.res.word = v > `VM_MAX ? 16'h7FFF : v < `VM_MIN ? 16'h8000 : 16'(v);
      2'h2:
        sio.res.word = q12 < 0 ? 16'h0000 : q12 > `FULL12 ? 16'h0FFF : 16'(q12);
      default:
        sio.res.word = u16 < 0 ? 16'h0000 : u16 > `MAX16 ? 16'hFFFF : 16'(u16);
    endcase
  end
endmodule // reading_scaler

// File: analog_input_map.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "aim_cfg.svh"
// Overview of operation
// - Nine contiguous read-only input words exposed
// - Words 1-8 channels, word 9 status
// - Warning when reading leaves normal band
// - Out-of-range keeps warning asserted
// - Out-of-range beyond rating plus 2.4 percent
// - Out-of-range below 0.5 V or 2.08 mA
// - Broken current wire reads zero current
// - 4-20 mA broken wire: fault, bits, status
// - Only module status MSB carries meaning
// - Module status set on any channel fault
// - 16-bit and 12-bit count scaling, clamped
// - Voltmeter format signed mV or uA
// - All channels refreshed every 5 ms
module analog_input_map #(
  parameter int NCH        = 8,
  parameter int UPDATE_CYC = `UPDATE_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    conv_req,
  output logic      [2:0]         conv_chan,
  input  wire logic               conv_valid,
  input  wire logic signed [17:0] conv_value,
  input  wire logic [NCH-1:0]     open_wire,
  output logic                    fault_led,
  output logic      [7:0]         module_status,
  output logic                    irq
);
  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic           rst_meta_r;
  logic           rst_sync_r;
  logic [NCH-1:0] open_meta_r;
  logic [NCH-1:0] open_sync_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      open_meta_r <= '0;
      open_sync_r <= '0;
    end
    else if (clk_en)
    begin
      open_meta_r <= open_wire;
      open_sync_r <= open_meta_r;
    end
  end

  // ****************************************
  // Scan sequencer
  // ****************************************
  typedef enum {st_idle, st_req, st_wait} scan_e;
  scan_e       st_r;
  logic [31:0] tick_cnt_r;
  logic        tick;
  logic        store;
  logic        overrun;
  logic        scan_done;

  assign tick = tick_cnt_r == 32'(UPDATE_CYC - 1);
  assign store = st_r == st_wait && conv_valid && clk_en;
  assign overrun = tick && st_r != st_idle && clk_en;
  assign scan_done = store && conv_chan == 3'(NCH - 1);

  // Fixed interval keeps the refresh period independent of bus traffic
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      tick_cnt_r <= 32'h0;
    else if (clk_en)
      tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      st_r      <= st_idle;
      conv_req  <= 1'b0;
      conv_chan <= 3'h0;
    end
    else if (clk_en)
    begin
      conv_req <= 1'b0;
      unique case (st_r)
        st_idle:
          if (tick)
          begin
            st_r      <= st_req;
            conv_chan <= 3'h0;
          end
        st_req:
        begin
          conv_req <= 1'b1;
          st_r     <= st_wait;
        end
        st_wait:
          if (conv_valid)
          begin
            conv_chan <= conv_chan + 3'h1;
            st_r      <= scan_done ? st_idle : st_req;
          end
      endcase
    end
  end

  // ****************************************
  // Scaling and per-channel storage
  // ****************************************
  logic [31:0]       config_r;
  logic [15:0]       word_r [NCH];
  logic [NCH-1:0]    warn_r;
  logic [NCH-1:0]    oor_r;
  logic [NCH-1:0]    fault_r;
  aim_pkg::reading_s res;
  scale_if           sio ();

  assign sio.value = conv_value;
  assign sio.rng = aim_pkg::range_e'(config_r[3 * int'(conv_chan) +: 3]);
  assign sio.fmt = config_r[`CFG_FMT_LSB +: 2];
  assign sio.open_wire = open_sync_r[conv_chan];
  assign res = sio.res;

  reading_scaler u_scaler (
    .sio (sio.scaler)
  );

  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_chan
      // Whole word and flags move in one edge, so reads never tear
      always_ff @(posedge clk or negedge rst_sync_r)
      begin
        if (!rst_sync_r)
        begin
          word_r[i]  <= 16'h0000;
          warn_r[i]  <= 1'b0;
          oor_r[i]   <= 1'b0;
          fault_r[i] <= 1'b0;
        end
        else if (store && conv_chan == 3'(i))
        begin
          word_r[i]  <= res.word;
          warn_r[i]  <= res.warn;
          oor_r[i]   <= res.oor;
          fault_r[i] <= res.fault;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      module_status <= 8'h00;
      fault_led     <= 1'b0;
    end
    else if (clk_en)
    begin
      module_status <= {|oor_r, 7'h00};
      fault_led     <= |fault_r;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic       access;
  logic       done;
  logic [5:0] idx;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_set;
  logic       stat_rd;
  logic       oor_rise;
  logic [31:0] rd_nxt;
  logic        err_nxt;

  // One wait state lets prdata leave a flop
  assign access = psel && penable && !pready && clk_en;
  assign done = psel && penable && pready && clk_en;
  assign idx = paddr[7:2];

  always_comb
  begin
    rd_nxt  = 32'h0;
    err_nxt = 1'b0;
    if (idx < 6'(NCH))
    begin
      rd_nxt  = {16'h0000, word_r[idx[2:0]]};
      err_nxt = pwrite;
    end
    else if (paddr == `OFF_STAT_WORD)
    begin
      rd_nxt  = {16'h0000, oor_r, warn_r};
      err_nxt = pwrite;
    end
    else if (paddr == `OFF_CONFIG)
      rd_nxt = config_r;
    else if (paddr == `OFF_IRQ_STAT)
      rd_nxt = {29'h0, irq_stat_r};
    else if (paddr == `OFF_IRQ_MASK)
      rd_nxt = {29'h0, irq_mask_r};
    else if (paddr == `OFF_MOD_STAT)
      rd_nxt = {24'h0, module_status};
    else
      err_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= access;
      if (access)
      begin
        prdata  <= pwrite ? 32'h0 : rd_nxt;
        pslverr <= err_nxt;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      config_r   <= `CFG_RST;
      irq_mask_r <= `MASK_RST;
    end
    else if (done && pwrite)
    begin
      if (paddr == `OFF_CONFIG)
        config_r <= pwdata;
      if (paddr == `OFF_IRQ_MASK)
        irq_mask_r <= pwdata[2:0];
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign oor_rise = store && res.oor && !oor_r[conv_chan];
  assign stat_rd = done && !pwrite && paddr == `OFF_IRQ_STAT;
  assign irq_set = {scan_done, overrun, oor_rise};

  // Clear only bits already returned, so no event slips between capture and clear
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      irq_stat_r <= 3'h0;
      irq        <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_stat_r <= (stat_rd ? irq_stat_r & ~prdata[2:0] : irq_stat_r) | irq_set;
      irq        <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_NINE_WORDS: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    access && !pwrite && paddr <= `OFF_STAT_WORD && paddr[1:0] == 2'h0
      |=> pready && !pslverr)
    else $error("channel or status word read refused");

  AST_RO_WORDS: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    access && pwrite && paddr <= `OFF_STAT_WORD |=> pslverr)
    else $error("write to read-only word not refused");

  AST_WORD_STORE: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    store |=> word_r[$past(conv_chan)] == $past(res.word))
    else $error("channel word not loaded from its conversion");

  AST_WARN_HELD: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    (oor_r & ~warn_r) == '0)
    else $error("out-of-range without warning");

  AST_OVER: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    store && sio.rng == aim_pkg::rng_bip10v && conv_value > 18'sd10240
      |=> oor_r[$past(conv_chan)] && warn_r[$past(conv_chan)])
    else $error("over-range not flagged");

  AST_LOW_CURRENT: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    store && sio.rng == aim_pkg::rng_off4_20ma && conv_value < 18'sd2080
      |=> oor_r[$past(conv_chan)] ##1 module_status[7])
    else $error("low current not flagged");

  AST_BROKEN_WIRE: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    store && sio.rng == aim_pkg::rng_off4_20ma && sio.open_wire
      |=> oor_r[$past(conv_chan)] ##1 fault_led && module_status[7])
    else $error("broken wire not reported");

  AST_ZERO_CURRENT: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    store && sio.rng == aim_pkg::rng_uni20ma && sio.fmt == 2'h1 && sio.open_wire
      |=> word_r[$past(conv_chan)] == 16'h0000)
    else $error("broken wire reading not zero");

  AST_MSB_ONLY: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    module_status[6:0] == 7'h00)
    else $error("unused module status bits set");

  AST_MOD_STAT: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    clk_en |=> module_status[7] == $past(|oor_r))
    else $error("module status does not follow channel faults");

  AST_B12_CLAMP: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    store && sio.fmt == 2'h2 |=> word_r[$past(conv_chan)] <= 16'h0FFF)
    else $error("12-bit reading above full count");

  AST_VOLTMETER: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    store && sio.fmt == 2'h1 && sio.open_wire == 1'b0 &&
      conv_value >= -18'sd10000 && conv_value <= 18'sd10000
      |=> word_r[$past(conv_chan)] == 16'($past(conv_value)))
    else $error("voltmeter word differs from reading");

  AST_SCAN_START: assert property (
    @(posedge clk) disable iff (!rst_sync_r)
    clk_en && tick && st_r == st_idle ##1 clk_en |=> conv_req && conv_chan == 3'h0)
    else $error("scan did not start on interval");
endmodule // analog_input_map

// File: front_end_model.sv
`timescale 1ns/1ps
// ****************************************
// Front end conversion model
// ****************************************
module front_end_model (
  input  wire logic               clk,
  input  wire logic               conv_req,
  input  wire logic [2:0]         conv_chan,
  input  wire logic               slow,
  input  wire logic signed [17:0] vals [8],
  output logic                    conv_valid,
  output logic signed [17:0]      conv_value
);
  logic signed [17:0] last;
  initial
  begin
    conv_valid = 1'h0;
    conv_value = 18'h00000;
    last       = 18'h00000;
    forever
    begin
      @(posedge clk);
      if (conv_req)
      begin
        // Slow answers keep the value line toggling so no stale value can pass
        repeat (slow ? 5 : 0)
        begin
          conv_value <= ~conv_value;
          @(posedge clk);
        end
        last = vals[conv_chan];
        conv_valid <= 1'h1;
        conv_value <= last;
        @(posedge clk);
        conv_valid <= 1'h0;
        conv_value <= ~last;
      end
      else
        conv_value <= ~conv_value;
    end
  end
endmodule // front_end_model

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  localparam int UPD = 200;
  typedef struct {logic signed [17:0] val; logic [15:0] word; logic warn; logic oor;} row_s;
  logic               clk, rst_b, clk_en, psel, penable, pwrite, slow, err;
  logic               pready, pslverr, conv_req, conv_valid, fault_led, irq;
  logic [7:0]         paddr, open_wire, module_status;
  logic [31:0]        pwdata, prdata, rd;
  logic [2:0]         conv_chan;
  logic signed [17:0] conv_value;
  logic signed [17:0] vals [8];
  int                 fail_count, n_tests, k;
  // ****************************************
  // Case table: scan s covers rows 8s..8s+7, channel = row mod 8
  // ****************************************
  row_s rows [24] = '{
    '{18'h02904, 16'h2904, 1'h1, 1'h1}, '{18'h3EC14, 16'hEC14, 1'h1, 1'h0},
    '{18'h01388, 16'h1388, 1'h0, 1'h0}, '{18'h01450, 16'h1450, 1'h1, 1'h1},
    '{18'h00190, 16'h0190, 1'h1, 1'h1}, '{18'h3B1E0, 16'hB1E0, 1'h0, 1'h0},
    '{18'h05000, 16'h5000, 1'h1, 1'h0}, '{18'h00834, 16'h0834, 1'h1, 1'h0},
    '{18'h3D8E6, 16'h02E0, 1'h1, 1'h0}, '{18'h01388, 16'hBE80, 1'h0, 1'h0},
    '{18'h02710, 16'hFA00, 1'h0, 1'h0}, '{18'h009C4, 16'h3E80, 1'h0, 1'h0},
    '{18'h01388, 16'h7D00, 1'h0, 1'h0}, '{18'h00000, 16'h8000, 1'h0, 1'h0},
    '{18'h02710, 16'h3E80, 1'h0, 1'h0}, '{18'h00FA0, 16'h1900, 1'h0, 1'h0},
    '{18'h02710, 16'h0FFF, 1'h0, 1'h0}, '{18'h3E890, 16'h0000, 1'h1, 1'h1},
    '{18'h00000, 16'h0000, 1'h0, 1'h0}, '{18'h01388, 16'h0FFF, 1'h0, 1'h0},
    '{18'h001F4, 16'h0000, 1'h1, 1'h0}, '{18'h00000, 16'h07FF, 1'h0, 1'h0},
    '{18'h04E20, 16'h0FFF, 1'h0, 1'h0}, '{18'h00800, 16'h0000, 1'h1, 1'h1}};
  logic [1:0]  fmts   [3] = '{2'h1, 2'h0, 2'h2};
  logic [15:0] stat_x [3] = '{16'h19DB, 16'h0001, 16'h8292};
  logic        mod_x  [3] = '{1'h1, 1'h0, 1'h1};
  logic        led_x  [3] = '{1'h1, 1'h0, 1'h1};

  analog_input_map #(.NCH(8), .UPDATE_CYC(UPD)) analog_input_map_i (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_req(conv_req), .conv_chan(conv_chan), .conv_valid(conv_valid),
    .conv_value(conv_value), .open_wire(open_wire), .fault_led(fault_led),
    .module_status(module_status), .irq(irq));
  front_end_model front_end_model_i (
    .clk(clk), .conv_req(conv_req), .conv_chan(conv_chan), .slow(slow), .vals(vals),
    .conv_valid(conv_valid), .conv_value(conv_value));

  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  // Poll scan-done twice so that one whole scan ran on the new settings
  task automatic wait_done;
    int n;
    repeat (2)
    begin
      n = 0;
      do
      begin
        apb(1'h0, 8'h28, 32'h0);
        n++;
      end
      while (rd[2] !== 1'h1 && n < 200);
      `CHK("scan done", 1'h1, rd[2])
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_b = 1'h0;
    {psel, penable, pwrite, slow} = 4'h0;
    clk_en = 1'h1;
    paddr = 8'h00;
    pwdata = 32'h0;
    open_wire = 8'h00;
    foreach (vals[i]) vals[i] = 18'h00000;
    fail_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    for (int s = 0; s < 3; s++)
    begin
      for (int r = 8 * s; r < 8 * s + 8; r++)
        vals[r % 8] <= rows[r].val;
      slow <= s[0];
      apb(1'h1, 8'h24, {6'h00, fmts[s], 24'hFAC688});
      wait_done();
      for (int r = 8 * s; r < 8 * s + 8; r++)
      begin
        apb(1'h0, 8'(4 * (r % 8)), 32'h0);
        `CHK("channel word", rows[r].word, rd[15:0])
      end
      apb(1'h0, 8'h20, 32'h0);
      `CHK("status word", stat_x[s], rd[15:0])
      `CHK("module status", {mod_x[s], 7'h00}, module_status)
      `CHK("fault led", led_x[s], fault_led)
    end
    // Read-only words and an unmapped address
    apb(1'h1, 8'h00, 32'h0000_1234);
    `CHK("ro word err", 1'h1, err)
    apb(1'h1, 8'h20, 32'h0000_FFFF);
    `CHK("ro status err", 1'h1, err)
    apb(1'h0, 8'h00, 32'h0);
    `CHK("ro word kept", 16'h0FFF, rd[15:0])
    apb(1'h0, 8'h34, 32'h0);
    `CHK("unmapped err", 1'h1, err)
    // Broken wires on current channels 6 and 7 (not bipolar channel 5) while the model still offers current
    open_wire <= 8'hC0;
    vals[7] <= 18'h02EE0;
    apb(1'h1, 8'h24, {6'h00, 2'h1, 24'hFAC688});
    wait_done();
    apb(1'h0, 8'h1C, 32'h0);
    `CHK("open wire word", 16'h0000, rd[15:0])
    apb(1'h0, 8'h18, 32'h0);
    `CHK("open wire zero", 16'h0000, rd[15:0])
    apb(1'h0, 8'h20, 32'h0);
    `CHK("open wire status", 16'h8292, rd[15:0])
    `CHK("open wire led", 1'h1, fault_led)
    `CHK("open wire module", 8'h80, module_status)
    // Clock enable low: no scan may start while frozen
    clk_en <= 1'h0;
    k = 0;
    repeat (UPD + 20)
    begin
      @(posedge clk);
      if (conv_req !== 1'h0)
        k++;
    end
    clk_en <= 1'h1;
    `CHK("frozen scan", 0, k)
    `CHK("frozen module", 8'h80, module_status)
    // Interrupt raised, cleared by read, then masked
    apb(1'h1, 8'h2C, 32'h0000_0004);
    apb(1'h0, 8'h28, 32'h0);
    k = 0;
    while (irq !== 1'h1 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    `CHK("irq raised", 1'h1, irq)
    apb(1'h0, 8'h28, 32'h0);
    `CHK("irq cause", 1'h1, rd[2])
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'h0, irq)
    apb(1'h1, 8'h2C, 32'h0);
    repeat (UPD + 20) @(posedge clk);
    `CHK("irq masked", 1'h0, irq)
    // Second reset in mid-run
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    `CHK("reset module", 8'h00, module_status)
    `CHK("reset led", 1'h0, fault_led)
    apb(1'h0, 8'h24, 32'h0);
    `CHK("reset config", 32'h0, rd)
    apb(1'h0, 8'h2C, 32'h0);
    `CHK("reset mask", 32'h0, rd)
    report_and_stop();
  end
endmodule // tb_top
